// file: rtl/bfs_pkg.sv
// Purpose: shared constants and types for the buck fault supervisor
// Assumes: 40 MHz system clock
// Notes: times are kept in their own units, cycle counts derived here
package bfs_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // switching frequency build options
    localparam int FSW_LO_HZ = 300_000;
    localparam int FSW_HI_HZ = 600_000;

    localparam int HICCUP_MS = 60;
    localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
    localparam int SOFT_MS = 8;
    localparam int SOFT_CYC = SOFT_MS * CLK_KHZ;
    localparam int RISE_MS = 120;
    localparam int RISE_CYC = RISE_MS * CLK_KHZ;
    localparam int FALL_US = 150;
    localparam int FALL_CYC = FALL_US * CLK_MHZ;
    // least times, rounded up to whole cycles
    localparam int BLANK_NS = 100;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_NS = 12;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;

    localparam int TW = 24;
    localparam int CW = 3;
    localparam int BW = 3;
    localparam logic [CW-1:0] OC_LIMIT = 3'h7;

    // register port map
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
    localparam logic CTRL_RST = 1'b0;
    localparam int CTRL_FIXED_BIT = 0;
    localparam int STAT_ST_LSB = 0;
    localparam int STAT_OK_BIT = 2;
    localparam int STAT_HS_LSB = 3;
    localparam int STAT_LS_LSB = 6;

    typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP}
        bfs_state_e;

    typedef struct packed {
        logic enable_input;
        logic uv_good;
        logic bias_ok;
        logic pwm_trip;
        logic hs_oc;
        logic ls_oc;
        logic fb_window;
        logic over_temp;
        logic hs_off_sense;
        logic ls_off_sense;
    } bfs_cmp_s;
endpackage : bfs_pkg

// file: rtl/bfs_top.sv
// Purpose: fault supervision and gate sequencing of a synchronous buck
// Assumes: comparator flags are asynchronous; analog loop is outside
// Notes: output_ok_flag is open drain, oe high pulls the pin low
// Operation
// R1: enable low enters shutdown, all off
// R2: hold off until input voltage good
// R3: bias regulator low forces shutdown
// R4: trip latch blocks high side until next cycle
// R5: one fixed switching frequency per build
// R6: high overcurrent cuts high side, counts up
// R7: clean cycle decrements high-side counter
// R8: count of seven faults, both drives off
// R9: wait hiccup delay, then restart
// R10: overcurrent in first restart cycle refaults
// R11: clean restart decrements, keeps running
// R12: low overcurrent keeps low on, counts up
// R13: low counter mirrors high-side fault handling
// R14: blank overcurrent flags after each turn-on
// R15: output ok low on any bad condition
// R16: output ok rises after long good hold
// R17: output ok falls after short delay
// R18: never both drives on, dead gap
// R19: fixed dead time option skips adaptive
// R20: drives low while disabled
// R21: soft start on every start
// R22: counters floor at zero, clear in shutdown
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module bfs_top #(
    parameter int FSW_HZ = bfs_pkg::FSW_LO_HZ,
    parameter int HICCUP_CYC = bfs_pkg::HICCUP_CYC,
    parameter int SOFT_CYC = bfs_pkg::SOFT_CYC,
    parameter int RISE_CYC = bfs_pkg::RISE_CYC,
    parameter int FALL_CYC = bfs_pkg::FALL_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // comparator flags from the analog front end
    input wire bfs_pkg::bfs_cmp_s cmp_raw,
    // register port
    input wire logic [bfs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // gate drives
    output logic high_gate_drive,
    output logic low_gate_drive,
    // open-drain output ok flag
    output logic output_ok_flag_o,
    output logic output_ok_flag_oe
);
    localparam int PER = bfs_pkg::CLK_HZ / FSW_HZ;
    localparam int PW = $clog2(PER);
    localparam logic [PW-1:0] PER_LAST = PW'(PER - 1);
    localparam int TW = bfs_pkg::TW;
    localparam int CW = bfs_pkg::CW;
    localparam int BW = bfs_pkg::BW;
    localparam logic [CW-1:0] LIM = bfs_pkg::OC_LIMIT;

    bfs_pkg::bfs_cmp_s sync1_q;
    bfs_pkg::bfs_cmp_s s;
    bfs_pkg::bfs_state_e st_q, st_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [PW-1:0] per_q, per_d;
    logic hs_done_q, hs_done_d;
    logic first_q, first_d;
    logic [CW-1:0] hs_cnt_q, hs_cnt_d, ls_cnt_q, ls_cnt_d;
    logic hs_hit_q, hs_hit_d, ls_hit_q, ls_hit_d;
    logic hs_q, hs_d, ls_q, ls_d;
    logic [BW-1:0] dt_q, dt_d, blk_q, blk_d;
    logic [TW-1:0] gd_q, gd_d, bd_q, bd_d;
    logic od_q, od_d;
    logic ctrl_q, ctrl_d;
    logic [31:0] rd_q, rd_d;
    logic run_ok, switching, cyc_start, blanked;
    logic hs_want, ls_want, hs_oc_ev, ls_oc_ev, fault, bad;
    logic ok_hs, ok_ls;

    // flags come from analog comparators: two stages before any use
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= '0;
            s <= '0;
        end
        else
        begin
            sync1_q <= cmp_raw;
            s <= sync1_q;
        end
    end

    // R1 R2 R3 start conditions
    assign run_ok = s.enable_input & s.uv_good & s.bias_ok & ~s.over_temp;
    assign switching = (st_q == bfs_pkg::ST_SOFT) |
                       (st_q == bfs_pkg::ST_RUN);
    // R5 cycle starts from the fixed period count
    assign cyc_start = switching & (per_q == '0);
    assign blanked = (blk_q != '0);
    // R4 high side only until the latch trips
    assign hs_want = switching & (~hs_done_q | cyc_start);
    assign ls_want = switching & hs_done_q & ~cyc_start;
    // R14 flags ignored inside the blanking window
    assign hs_oc_ev = s.hs_oc & hs_q & ~blanked;
    assign ls_oc_ev = s.ls_oc & ls_q & ~blanked;

    // sequencing, cycle timing and overcurrent counters
    always_comb
    begin
        st_d = st_q;
        tmr_d = tmr_q;
        per_d = (!switching || per_q == PER_LAST) ? '0 : per_q + 1'b1;
        first_d = first_q;
        hs_done_d = hs_done_q;
        hs_cnt_d = hs_cnt_q;
        ls_cnt_d = ls_cnt_q;
        hs_hit_d = hs_hit_q;
        ls_hit_d = ls_hit_q;
        fault = 1'b0;
        if (cyc_start)
        begin
            hs_done_d = 1'b0;
            // R7 R11 R13 clean cycle decrement
            if (!first_q)
            begin
                // R22 floor at zero
                if (!hs_hit_q && hs_cnt_q != '0)
                    hs_cnt_d = hs_cnt_q - 1'b1;
                if (!ls_hit_q && ls_cnt_q != '0)
                    ls_cnt_d = ls_cnt_q - 1'b1;
            end
            first_d = 1'b0;
            hs_hit_d = 1'b0;
            ls_hit_d = 1'b0;
        end
        // R4 trip latch set
        else if (hs_q && (s.pwm_trip || hs_oc_ev))
            hs_done_d = 1'b1;
        // R6 count one high-side event per cycle
        if (hs_oc_ev && !hs_hit_d)
        begin
            hs_hit_d = 1'b1;
            if (hs_cnt_d != LIM)
                hs_cnt_d = hs_cnt_d + 1'b1;
        end
        // R12 count one low-side event per cycle
        if (ls_oc_ev && !ls_hit_d)
        begin
            ls_hit_d = 1'b1;
            if (ls_cnt_d != LIM)
                ls_cnt_d = ls_cnt_d + 1'b1;
        end
        // R8 R10 R13 counter at seven is a fault at once
        fault = switching & ((hs_oc_ev & (hs_cnt_d == LIM)) |
                             (ls_oc_ev & (ls_cnt_d == LIM)));
        case (st_q)
            bfs_pkg::ST_OFF:
            begin
                // R22 counters clear while shut down
                hs_cnt_d = '0;
                ls_cnt_d = '0;
                first_d = 1'b0;
                // R21 every start runs soft start
                if (run_ok)
                begin
                    st_d = bfs_pkg::ST_SOFT;
                    tmr_d = TW'(SOFT_CYC - 1);
                end
            end
            bfs_pkg::ST_SOFT:
            begin
                if (tmr_q == '0)
                    st_d = bfs_pkg::ST_RUN;
                else
                    tmr_d = tmr_q - 1'b1;
            end
            bfs_pkg::ST_RUN:
                tmr_d = '0;
            bfs_pkg::ST_HICCUP:
            begin
                // R9 R21 restart through soft start
                if (tmr_q == '0)
                begin
                    st_d = bfs_pkg::ST_SOFT;
                    tmr_d = TW'(SOFT_CYC - 1);
                end
                else
                    tmr_d = tmr_q - 1'b1;
            end
            default:
                st_d = bfs_pkg::ST_OFF;
        endcase
        // R8 R9 fault holds both off for the hiccup delay
        if (fault)
        begin
            st_d = bfs_pkg::ST_HICCUP;
            tmr_d = TW'(HICCUP_CYC - 1);
            first_d = 1'b1;
            hs_done_d = 1'b0;
            hs_hit_d = 1'b0;
            ls_hit_d = 1'b0;
        end
        // R1 R2 R3 shutdown wins over everything
        if (!run_ok)
        begin
            st_d = bfs_pkg::ST_OFF;
            tmr_d = '0;
            hs_done_d = 1'b0;
            hs_hit_d = 1'b0;
            ls_hit_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= bfs_pkg::ST_OFF;
            tmr_q <= '0;
            per_q <= '0;
            first_q <= 1'b0;
            hs_done_q <= 1'b0;
            hs_cnt_q <= '0;
            ls_cnt_q <= '0;
            hs_hit_q <= 1'b0;
            ls_hit_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            per_q <= per_d;
            first_q <= first_d;
            hs_done_q <= hs_done_d;
            hs_cnt_q <= hs_cnt_d;
            ls_cnt_q <= ls_cnt_d;
            hs_hit_q <= hs_hit_d;
            ls_hit_q <= ls_hit_d;
        end
    end

    // R19 fixed gap, else wait for the other gate to read off
    assign ok_hs = ctrl_q ? (dt_q == '0) : s.ls_off_sense;
    assign ok_ls = ctrl_q ? (dt_q == '0) : s.hs_off_sense;

    // gate drive sequencer
    always_comb
    begin
        hs_d = hs_q;
        ls_d = ls_q;
        dt_d = (dt_q != '0) ? dt_q - 1'b1 : '0;
        // R6 R20 immediate turn-off
        if (!hs_want || hs_oc_ev)
            hs_d = 1'b0;
        // R12 low side ends at cycle start or when switching stops
        if (!ls_want)
            ls_d = 1'b0;
        if ((hs_q && !hs_d) || (ls_q && !ls_d))
            dt_d = BW'(bfs_pkg::DEAD_CYC);
        // R18 turn-on only with both gates off
        if (hs_want && !hs_oc_ev && !hs_q && !ls_q && ok_hs)
            hs_d = 1'b1;
        if (ls_want && !hs_q && !ls_q && ok_ls)
            ls_d = 1'b1;
        // R14 blanking restarts at every turn-on
        if ((hs_d && !hs_q) || (ls_d && !ls_q))
            blk_d = BW'(bfs_pkg::BLANK_CYC);
        else
            blk_d = blanked ? blk_q - 1'b1 : '0;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            dt_q <= '0;
            blk_q <= '0;
        end
        else
        begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            dt_q <= dt_d;
            blk_q <= blk_d;
        end
    end

    // R15 any bad condition; not running covers soft start and faults
    assign bad = ~s.fb_window | (st_q != bfs_pkg::ST_RUN) |
                 s.hs_oc | s.ls_oc | s.over_temp;

    // output ok filter: slow release, short pull-down
    always_comb
    begin
        gd_d = gd_q;
        bd_d = bd_q;
        od_d = od_q;
        if (bad)
        begin
            gd_d = '0;
            // R17 pull low after the fall delay
            if (bd_q == TW'(FALL_CYC - 1))
                od_d = 1'b1;
            else
                bd_d = bd_q + 1'b1;
        end
        else
        begin
            bd_d = '0;
            // R16 release after a continuous good hold
            if (gd_q == TW'(RISE_CYC - 1))
                od_d = 1'b0;
            else
                gd_d = gd_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gd_q <= '0;
            bd_q <= '0;
            od_q <= 1'b1;
        end
        else
        begin
            gd_q <= gd_d;
            bd_q <= bd_d;
            od_q <= od_d;
        end
    end

    // register port: control word and live status
    always_comb
    begin
        ctrl_d = ctrl_q;
        rd_d = '0;
        if (reg_wr && reg_addr == bfs_pkg::REG_CTRL)
            ctrl_d = reg_wdata[bfs_pkg::CTRL_FIXED_BIT];
        if (reg_rd)
        begin
            case (reg_addr)
                bfs_pkg::REG_CTRL:
                    rd_d[bfs_pkg::CTRL_FIXED_BIT] = ctrl_q;
                bfs_pkg::REG_STAT:
                begin
                    rd_d[bfs_pkg::STAT_ST_LSB +: 2] = st_q;
                    rd_d[bfs_pkg::STAT_OK_BIT] = ~od_q;
                    rd_d[bfs_pkg::STAT_HS_LSB +: CW] = hs_cnt_q;
                    rd_d[bfs_pkg::STAT_LS_LSB +: CW] = ls_cnt_q;
                end
                default:
                    rd_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= bfs_pkg::CTRL_RST;
            rd_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rd_q <= rd_d;
        end
    end

    assign reg_rdata = rd_q;
    assign high_gate_drive = hs_q;
    assign low_gate_drive = ls_q;
    // open drain: level is always low, only the enable moves
    assign output_ok_flag_o = 1'b0;
    assign output_ok_flag_oe = od_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_no_overlap: assert property ( // R18
        !(high_gate_drive && low_gate_drive))
        else $error("both gate drives on");
    a_enable_input_off: assert property ( // R1
        !s.enable_input |=> st_q == bfs_pkg::ST_OFF)
        else $error("enable low did not shut down");
    a_off_drives: assert property ( // R20
        !s.enable_input |-> ##2 !high_gate_drive && !low_gate_drive)
        else $error("drive on while disabled");
    a_uv_hold: assert property ( // R2
        !s.uv_good |=> st_q == bfs_pkg::ST_OFF)
        else $error("ran without input voltage good");
    a_bias_drop: assert property ( // R3
        !s.bias_ok |=> st_q == bfs_pkg::ST_OFF)
        else $error("ran with bias regulator low");
    a_latch_hold: assert property ( // R4
        hs_done_q && !cyc_start |=> !$rose(high_gate_drive))
        else $error("high side retriggered in cycle");
    a_hs_cut: assert property ( // R6
        hs_oc_ev |=> !high_gate_drive)
        else $error("high side not cut on overcurrent");
    a_hs_dec: assert property ( // R7
        cyc_start && !hs_hit_q && !first_q && hs_cnt_q != '0 &&
        !hs_oc_ev && run_ok |=> hs_cnt_q == $past(hs_cnt_q) - 1'b1)
        else $error("counter did not decrement");
    a_fault_entry: assert property ( // R8
        run_ok && switching && hs_oc_ev && !hs_hit_q &&
        hs_cnt_q == LIM - 1'b1 |=> st_q == bfs_pkg::ST_HICCUP &&
        !high_gate_drive)
        else $error("seventh event did not fault");
    a_refault: assert property ( // R10
        run_ok && switching && ls_oc_ev && ls_cnt_q == LIM
        |=> st_q == bfs_pkg::ST_HICCUP)
        else $error("first restart cycle did not refault");
    a_hiccup_load: assert property ( // R9
        st_q != bfs_pkg::ST_HICCUP ##1 st_q == bfs_pkg::ST_HICCUP
        |-> tmr_q == TW'(HICCUP_CYC - 1))
        else $error("hiccup delay not loaded");
    a_restart_soft: assert property ( // R21
        st_q == bfs_pkg::ST_HICCUP && tmr_q == '0 && run_ok
        |=> st_q == bfs_pkg::ST_SOFT && tmr_q == TW'(SOFT_CYC - 1))
        else $error("restart skipped soft start");
    a_ls_hold: assert property ( // R12
        ls_oc_ev && ls_want && !cyc_start |=> low_gate_drive)
        else $error("low side cut on overcurrent");
    a_fixed_gap: assert property ( // R19
        ctrl_q && $fell(low_gate_drive) |=> !high_gate_drive)
        else $error("fixed dead gap missing");
    a_ok_fall: assert property ( // R17
        bad && bd_q == TW'(FALL_CYC - 1) |=> output_ok_flag_oe)
        else $error("output ok not pulled low");
    a_ok_rise: assert property ( // R16
        $fell(output_ok_flag_oe) |-> $past(gd_q) == TW'(RISE_CYC - 1))
        else $error("output ok released early");
    a_off_clear: assert property ( // R22
        st_q == bfs_pkg::ST_OFF |=> hs_cnt_q == '0 && ls_cnt_q == '0)
        else $error("counters not cleared in shutdown");

    c_hiccup: cover property (st_q == bfs_pkg::ST_HICCUP);
    c_ok_high: cover property ($fell(output_ok_flag_oe));
    c_hs_oc: cover property (hs_oc_ev);
    c_ls_oc: cover property (ls_oc_ev ##1 low_gate_drive);
endmodule : bfs_top

// file: bench/bfs_pwr_stage.sv
// Purpose: behavioural power stage and comparator front end
// Assumes: drives are registered levels, one clock domain
// Notes: slow stretches the off-sense lag to mimic sluggish gates
`timescale 1ns/1ps
module bfs_pwr_stage #(
    parameter int DUTY = 40
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // gate drives from the supervisor
    input wire logic high_gate_drive,
    input wire logic low_gate_drive,
    // scenario controls
    input wire logic slow,
    input wire logic hs_fault,
    input wire logic ls_fault,
    // comparator flags
    output logic pwm_trip,
    output logic hs_oc,
    output logic ls_oc,
    output logic hs_off_sense,
    output logic ls_off_sense
);
    logic [3:0] hs_q;
    logic [3:0] ls_q;
    int on_q;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hs_q <= 4'h0;
            ls_q <= 4'h0;
            on_q <= 0;
        end
        else
        begin
            hs_q <= {hs_q[2:0], high_gate_drive};
            ls_q <= {ls_q[2:0], low_gate_drive};
            on_q <= high_gate_drive ? on_q + 1 : 0;
        end
    end
    // a gate reads off only once its charge has drained
    assign hs_off_sense = slow ? ~|hs_q : ~hs_q[0];
    assign ls_off_sense = slow ? ~|ls_q : ~ls_q[0];
    assign pwm_trip = high_gate_drive && on_q >= DUTY;
    // a shorted stage shows overcurrent whenever its switch conducts
    assign hs_oc = hs_fault && high_gate_drive;
    assign ls_oc = ls_fault && low_gate_drive;
endmodule : bfs_pwr_stage

// file: bench/bfs_top_tb.sv
// Purpose: self-checking bench for the buck fault supervisor
// Assumes: shortened delays through the top parameters
// Notes: status is polled over the register port
`timescale 1ns/1ps
module bfs_top_tb;
    localparam int HIC = 200;
    localparam int SFT = 50;
    localparam int RSE = 100;
    localparam int FLL = 20;
    localparam int PER = bfs_pkg::CLK_HZ / bfs_pkg::FSW_LO_HZ;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic high_gate_drive;
    logic low_gate_drive;
    logic ok_o;
    logic ok_oe;
    logic en = 1'b0;
    logic uvg = 1'b0;
    logic bok = 1'b0;
    logic fbw = 1'b0;
    logic otp = 1'b0;
    logic slow = 1'b0;
    logic hs_fault = 1'b0;
    logic ls_fault = 1'b0;
    logic trip, hs_oc, ls_oc, hs_off, ls_off;
    bfs_pkg::bfs_cmp_s cmp;
    int num_errors = 0;
    int cmp_count = 0;
    int overlap = 0;
    int gap = 0;
    int min_gap = 1000;
    int drv_cnt = 0;
    int cyc = 0;
    int hi_rise = 0;
    int per_seen = 0;
    logic hi_prev = 1'b0;
    logic [31:0] d;
    logic [2:0] c;

    assign cmp = '{enable_input: en, uv_good: uvg, bias_ok: bok,
        pwm_trip: trip, hs_oc: hs_oc, ls_oc: ls_oc, fb_window: fbw,
        over_temp: otp, hs_off_sense: hs_off, ls_off_sense: ls_off};

    bfs_top #(.HICCUP_CYC(HIC), .SOFT_CYC(SFT), .RISE_CYC(RSE),
        .FALL_CYC(FLL)) DUT (.clk_sys(clk_sys), .resetn(resetn),
        .cmp_raw(cmp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
        .output_ok_flag_o(ok_o), .output_ok_flag_oe(ok_oe));

    bfs_pwr_stage stage (.clk_sys(clk_sys), .resetn(resetn),
        .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
        .slow(slow), .hs_fault(hs_fault), .ls_fault(ls_fault),
        .pwm_trip(trip), .hs_oc(hs_oc), .ls_oc(ls_oc),
        .hs_off_sense(hs_off), .ls_off_sense(ls_off));

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // gate watcher: overlap, dead gap, period, activity
    always @(posedge clk_sys)
    begin
        if (high_gate_drive === 1'b1 && low_gate_drive === 1'b1)
            overlap++;
        if (high_gate_drive === 1'b0 && low_gate_drive === 1'b0)
            gap++;
        else
        begin
            if (gap > 0 && gap < min_gap)
                min_gap = gap;
            gap = 0;
            drv_cnt++;
        end
        if (high_gate_drive === 1'b1 && !hi_prev)
        begin
            per_seen = cyc - hi_rise;
            hi_rise = cyc;
        end
        hi_prev = high_gate_drive;
        cyc++;
    end

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic wait_st(input logic [1:0] st, input int lim,
        input string nm);
        logic [31:0] v;
        int n;
        n = 0;
        rd(bfs_pkg::REG_STAT, v);
        while (v[1:0] !== st && n < lim)
        begin
            rd(bfs_pkg::REG_STAT, v);
            n++;
        end
        chk(nm, {30'h0, st}, {30'h0, v[1:0]});
    endtask : wait_st

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    initial
    begin
        #(25ns * 100000);
        num_errors++;
        end_sim();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(1);
        chk("drives_off", 32'h0,
            {30'h0, high_gate_drive, low_gate_drive});
        chk("ok_low", 32'h1, {31'h0, ok_oe});
        chk("ok_level", 32'h0, {31'h0, ok_o});
        rd(bfs_pkg::REG_STAT, d);
        chk("stat_rst", 32'h0, d);
        rd(bfs_pkg::REG_CTRL, d);
        chk("ctrl_rst", 32'h0, d);
        rd(4'h8, d);
        chk("unmapped_rd", 32'h0, d);
        wr(bfs_pkg::REG_CTRL, 32'h1);
        wr(4'hc, 32'h0);
        rd(bfs_pkg::REG_CTRL, d);
        chk("ctrl_rw", 32'h1, d);
        wr(bfs_pkg::REG_CTRL, 32'h0);
        $display("test registers done");

        en <= 1'b1;
        bok <= 1'b1;
        // drives read unknown before the first reset edge
        drv_cnt = 0;
        tick(20);
        chk("no_start_uv", 32'h0, drv_cnt);
        uvg <= 1'b1;
        fbw <= 1'b1;
        wait_st(bfs_pkg::ST_SOFT, 20, "soft_first");
        tick(SFT - 20);
        wait_st(bfs_pkg::ST_SOFT, 0, "soft_holds");
        wait_st(bfs_pkg::ST_RUN, 40, "run");
        tick(RSE - 10);
        chk("ok_not_yet", 32'h1, {31'h0, ok_oe});
        tick(20);
        chk("ok_released", 32'h0, {31'h0, ok_oe});
        fbw <= 1'b0;
        tick(FLL - 3);
        chk("ok_fall_wait", 32'h0, {31'h0, ok_oe});
        tick(9);
        chk("ok_fall", 32'h1, {31'h0, ok_oe});
        fbw <= 1'b1;
        tick(3 * PER);
        chk("period", PER, per_seen);
        chk("overlap", 32'h0, overlap);
        $display("test run done");

        for (int s = 0; s < 2; s++)
        begin
            hs_fault <= (s == 0);
            ls_fault <= (s == 1);
            tick(2 * PER);
            rd(bfs_pkg::REG_STAT, d);
            c = (s == 0) ? d[5:3] : d[8:6];
            chk("count_up", 32'h1, {31'h0, c >= 1 && c <= 3});
            wait_st(bfs_pkg::ST_HICCUP, 700, "to_hiccup");
            rd(bfs_pkg::REG_STAT, d);
            c = (s == 0) ? d[5:3] : d[8:6];
            chk("count_seven", 32'h7, {29'h0, c});
            drv_cnt = 0;
            tick(150);
            chk("hiccup_off", 32'h0, drv_cnt);
            chk("hiccup_ok", 32'h1, {31'h0, ok_oe});
            wait_st(bfs_pkg::ST_SOFT, 100, "restart");
            wait_st(bfs_pkg::ST_HICCUP, 300, "refault");
            hs_fault <= 1'b0;
            ls_fault <= 1'b0;
            wait_st(bfs_pkg::ST_SOFT, 150, "restart2");
            wait_st(bfs_pkg::ST_RUN, 60, "run_again");
            tick(3 * PER);
            rd(bfs_pkg::REG_STAT, d);
            c = (s == 0) ? d[5:3] : d[8:6];
            chk("count_down", 32'h1, {31'h0, c >= 2 && c <= 5});
            tick(10 * PER);
            rd(bfs_pkg::REG_STAT, d);
            chk("count_floor", 32'h0, {26'h0, d[8:3]});
            $display("test overcurrent side %0d done", s);
        end

        for (int k = 0; k < 4; k++)
        begin
            hs_fault <= 1'b1;
            tick(2 * PER);
            hs_fault <= 1'b0;
            en <= (k != 0);
            uvg <= (k != 1);
            bok <= (k != 2);
            otp <= (k == 3);
            wait_st(bfs_pkg::ST_OFF, 20, "shutdown");
            tick(2);
            chk("off_drives", 32'h0,
                {30'h0, high_gate_drive, low_gate_drive});
            tick(FLL);
            chk("off_ok", 32'h1, {31'h0, ok_oe});
            en <= 1'b1;
            uvg <= 1'b1;
            bok <= 1'b1;
            otp <= 1'b0;
            wait_st(bfs_pkg::ST_SOFT, 20, "soft_again");
            rd(bfs_pkg::REG_STAT, d);
            chk("count_clear", 32'h0, {26'h0, d[8:3]});
            wait_st(bfs_pkg::ST_RUN, 40, "run_k");
        end
        $display("test shutdown done");

        slow <= 1'b1;
        tick(PER);
        min_gap = 1000;
        tick(3 * PER);
        chk("slow_gap", 32'h1, {31'h0, min_gap >= 7});
        wr(bfs_pkg::REG_CTRL, 32'h1);
        tick(PER);
        min_gap = 1000;
        tick(3 * PER);
        chk("fixed_gap", 32'h2, min_gap);
        chk("overlap_all", 32'h0, overlap);
        $display("test dead time done");
        end_sim();
    end
endmodule : bfs_top_tb
